// ---- rtl/osf_pkg.sv ----
// Package for the octal switch fault logic: widths, timing and word layout.
// Assumes a 50 MHz system clock; used by osf_fault_logic.
package osf_pkg;
    localparam int          NUM_OUT        = 8;
    localparam int          STATUS_W       = 16;
    localparam int          CLK_MHZ        = 50;
    // Filter window is 100 us to 300 us; terminal count sits at 200 us.
    localparam int          FILT_MIN_US    = 100;
    localparam int          FILT_MAX_US    = 300;
    localparam int          FILT_US        = 200;
    localparam int          FILT_CYC       = FILT_US * CLK_MHZ;
    localparam int          FILT_MIN_CYC   = FILT_MIN_US * CLK_MHZ;
    localparam int          FILT_MAX_CYC   = FILT_MAX_US * CLK_MHZ;
    localparam int          TMR_W          = 16;
    localparam logic [7:0]  STATUS_HI_ZERO = 8'h00;
    localparam logic [7:0]  OUT_ALL_OFF    = 8'h00;
    localparam logic [7:0]  OLD_RESET      = 8'h00;
    localparam logic [15:0] TMR_ZERO       = 16'h0000;
    localparam logic [15:0] TMR_ONE        = 16'h0001;
endpackage

// ---- rtl/osf_sync.sv ----
// Two-flop synchroniser for a bus of asynchronous levels.
// Assumes the inputs are quasi-static compared with the 50 MHz clock.
`timescale 1ns/10ps
module osf_sync #(
    parameter int W = 8
) (
    input  wire logic         clk_sys,
    input  wire logic         rstn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_sync_out;

    always_comb
    begin
        next_meta     = async_in;
        next_sync_out = meta;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            meta     <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta     <= next_meta;
            sync_out <= next_sync_out;
        end
    end
endmodule

// ---- rtl/osf_fault_logic.sv ----
// Fault detection and status latching for an eight-output power switch.
// Assumes command/enable words arrive already decoded from the serial port,
// with cmd_load pulsing for one clock when chip select rises.
`timescale 1ns/10ps
// Overview of operation
// R1 - Open-load is only checked on outputs whose command bit is low.
// R2 - One comparator per output flags open load below the threshold.
// R3 - Serial command switches the detection current; controller must enable it.
// R4 - After reset the detection current is off until enabled.
// R5 - Logic supply or enable loss forces every detection current off.
// R6 - A 100 to 300 us filter hides false open-load faults.
// R7 - Each chip-select rising edge restarts the fault delay timer.
// R8 - Open-load results are ignored until the delay timer expires.
// R9 - Detected faults stay latched in the status word until read.
// R10 - Thermal limit switches off only the affected output.
// R11 - A cooled output is switched back on automatically.
// R12 - Thermal retry repeats until fault clears or command bit clears.
// R13 - Short faults are reported regardless of detection current enables.
// R14 - Undervoltage on either supply switches all outputs off.
// R15 - Supplies restored: logic resets, then normal operation resumes.
// R16 - Status bits 0..7 are per-output faults; bits 8..15 read zero.
// R17 - With detection current disabled, open-load status reads zero.
// R18 - Sleep returns registers to reset: outputs off, current disabled.
// R19 - Controller leaves over 300 us between command writes.
// R20 - Delay timer is a clock counter ending inside the filter window.
// R21 - Comparator and thermal inputs are synchronised before use.
module osf_fault_logic #(
    parameter int NUM_OUT  = osf_pkg::NUM_OUT,
    parameter int FILT_CYC = osf_pkg::FILT_CYC
) (
    input  wire logic                     clk_sys,
    input  wire logic                     rstn,
    input  wire logic                     logic_supply_ok,
    input  wire logic                     enable_pin,
    input  wire logic                     load_power_supply_ok,
    input  wire logic                     cmd_load,
    input  wire logic [NUM_OUT-1:0]       cmd_out,
    input  wire logic [NUM_OUT-1:0]       cmd_old_en,
    input  wire logic                     status_read,
    input  wire logic [NUM_OUT-1:0]       open_load_cmp,
    input  wire logic [NUM_OUT-1:0]       short_cmp,
    input  wire logic [NUM_OUT-1:0]       thermal_limit,
    output logic      [NUM_OUT-1:0]       out_drive,
    output logic      [NUM_OUT-1:0]       old_current_en,
    output logic      [osf_pkg::STATUS_W-1:0] status_word,
    output logic                          filter_done
);
    // Supply and enable pins are asynchronous, so they pass the synchroniser
    // too; the comparators and thermal flags share one instance.
    localparam int SW = 3 * NUM_OUT + 3;

    logic [SW-1:0]          sync_raw;
    logic [SW-1:0]          sync_q;
    logic [NUM_OUT-1:0]     ol_s;
    logic [NUM_OUT-1:0]     sc_s;
    logic [NUM_OUT-1:0]     tl_s;
    logic                   vdd_ok_s;
    logic                   en_s;
    logic                   lps_ok_s;
    logic                   sleep;
    logic                   uv;
    logic                   soft_rst;
    logic [NUM_OUT-1:0]     cmd_reg;
    logic [NUM_OUT-1:0]     next_cmd_reg;
    logic [NUM_OUT-1:0]     old_reg;
    logic [NUM_OUT-1:0]     next_old_reg;
    logic [NUM_OUT-1:0]     flt;
    logic [NUM_OUT-1:0]     next_flt;
    logic [NUM_OUT-1:0]     next_out_drive;
    logic [osf_pkg::TMR_W-1:0] tmr;
    logic [osf_pkg::TMR_W-1:0] next_tmr;
    logic                   next_filter_done;
    logic [NUM_OUT-1:0]     ol_event;
    logic [NUM_OUT-1:0]     sc_event;
    logic [NUM_OUT-1:0]     next_flt_keep;

    localparam logic [osf_pkg::TMR_W-1:0] TMR_END =
        osf_pkg::TMR_W'(FILT_CYC - 1);

    assign sync_raw = {load_power_supply_ok, enable_pin, logic_supply_ok,
                       thermal_limit, short_cmp, open_load_cmp};

    osf_sync #(
        .W        (SW)
    ) u_sync (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .async_in (sync_raw),
        .sync_out (sync_q)
    );

    // Synchronised view of every analog flag.
    assign ol_s      = sync_q[NUM_OUT-1:0];               // R21
    assign sc_s      = sync_q[2*NUM_OUT-1:NUM_OUT];       // R21
    assign tl_s      = sync_q[3*NUM_OUT-1:2*NUM_OUT];     // R21
    assign vdd_ok_s  = sync_q[3*NUM_OUT];
    assign en_s      = sync_q[3*NUM_OUT+1];
    assign lps_ok_s  = sync_q[3*NUM_OUT+2];

    assign sleep    = !vdd_ok_s || !en_s;                 // R5 R18
    assign uv       = !vdd_ok_s || !lps_ok_s;             // R14
    // Any loss of supply or enable holds the logic in its reset state, so
    // the return of both supplies restarts from a clean state.
    assign soft_rst = sleep || uv;                        // R15

    // Command and detection-current registers.
    always_comb
    begin
        next_cmd_reg = cmd_reg;
        next_old_reg = old_reg;
        if (soft_rst)
        begin
            next_cmd_reg = osf_pkg::OUT_ALL_OFF;          // R18
            next_old_reg = osf_pkg::OLD_RESET;            // R4 R5 R18
        end
        else if (cmd_load)
        begin
            next_cmd_reg = cmd_out;
            next_old_reg = cmd_old_en;                    // R3
        end
    end

    // Delay timer restarted by every chip-select rise.
    always_comb
    begin
        next_tmr         = tmr;
        next_filter_done = filter_done;
        if (soft_rst || cmd_load)
        begin
            next_tmr         = osf_pkg::TMR_ZERO;         // R7
            next_filter_done = 1'b0;                      // R7
        end
        else if (!filter_done)
        begin
            if (tmr == TMR_END)
                next_filter_done = 1'b1;                  // R20 R6
            else
                next_tmr = tmr + osf_pkg::TMR_ONE;        // R20
        end
    end

    // Outputs follow the command, minus thermal shutdown per channel; the
    // thermal flag clearing brings the channel back, which is the retry.
    always_comb
    begin
        if (uv || soft_rst)
            next_out_drive = osf_pkg::OUT_ALL_OFF;        // R14
        else
            next_out_drive = cmd_reg & ~tl_s;             // R10 R11 R12
    end

    // Fault capture: a new event wins over the read clear.
    assign ol_event = ~cmd_reg & old_reg & ol_s
                      & {NUM_OUT{filter_done}};           // R1 R2 R8 R17
    assign sc_event = cmd_reg & (sc_s | tl_s);            // R13

    always_comb
    begin
        next_flt_keep = status_read ? osf_pkg::OUT_ALL_OFF : flt;  // R9
        if (soft_rst)
            next_flt = osf_pkg::OUT_ALL_OFF;
        else
            next_flt = next_flt_keep | ol_event | sc_event;        // R9
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            cmd_reg     <= '0;
            old_reg     <= '0;
            tmr         <= '0;
            filter_done <= 1'b0;
            out_drive   <= '0;
            flt         <= '0;
        end
        else
        begin
            cmd_reg     <= next_cmd_reg;
            old_reg     <= next_old_reg;
            tmr         <= next_tmr;
            filter_done <= next_filter_done;
            out_drive   <= next_out_drive;
            flt         <= next_flt;
        end
    end

    assign old_current_en = old_reg;
    assign status_word    = {osf_pkg::STATUS_HI_ZERO, flt};  // R16

    // Helper count of cycles since the last restart, for the window check.
    // It is kept apart from the timer so the check does not reuse its logic.
    logic [osf_pkg::TMR_W-1:0] since_cs;
    logic [osf_pkg::TMR_W-1:0] next_since_cs;

    always_comb
    begin
        next_since_cs = since_cs;
        if (soft_rst || cmd_load)
            next_since_cs = osf_pkg::TMR_ZERO;
        else if (!filter_done)
            next_since_cs = since_cs + osf_pkg::TMR_ONE;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            since_cs <= '0;
        else
            since_cs <= next_since_cs;
    end

    sequence s_cs_restart;
        cmd_load && !soft_rst;
    endsequence

    sequence s_timer_idle;
        !filter_done && (tmr == osf_pkg::TMR_ZERO);
    endsequence

    // A bit that newly sets on an output that is on must come from a short or thermal flag.
    AST_OL_ONLY_OFF: assert property (@(posedge clk_sys)  // R1
        disable iff (!rstn)
        !soft_rst
        |=> ((flt & ~$past(flt) & $past(cmd_reg) & ~$past(sc_event))
             == '0))
        else $error("Open load flagged on an output that is on.");

    AST_OL_SETS: assert property (@(posedge clk_sys)  // R2
        disable iff (!rstn)
        (!soft_rst && filter_done && (ol_event != '0))
        |=> ((flt & $past(ol_event)) == $past(ol_event)))
        else $error("Open-load comparator did not set its fault bit.");

    AST_OLD_CMD: assert property (@(posedge clk_sys)  // R3
        disable iff (!rstn)
        s_cs_restart |=> (old_current_en == $past(cmd_old_en)))
        else $error("Detection enable not taken from the command.");

    AST_OLD_HOLD: assert property (@(posedge clk_sys)  // R4
        disable iff (!rstn)
        (!cmd_load && !soft_rst) |=> $stable(old_current_en))
        else $error("Detection enable changed without a command.");

    AST_OLD_OFF_SLEEP: assert property (@(posedge clk_sys)  // R5 R18
        disable iff (!rstn)
        sleep |=> (old_current_en == '0 && cmd_reg == '0
                   && flt == '0 && !filter_done))
        else $error("Registers not at their reset state during sleep.");

    AST_FILT_WINDOW: assert property (@(posedge clk_sys)  // R6 R20
        disable iff (!rstn)
        $rose(filter_done) |-> (since_cs == osf_pkg::TMR_W'(FILT_CYC)))
        else $error("Filter did not end at its terminal count.");

    AST_CS_RESTART: assert property (@(posedge clk_sys)  // R7
        disable iff (!rstn)
        s_cs_restart |=> s_timer_idle ##1 !filter_done)
        else $error("Chip-select rise did not restart the delay timer.");

    AST_NO_OL_EARLY: assert property (@(posedge clk_sys)  // R8
        disable iff (!rstn)
        (!filter_done && !status_read && !soft_rst && sc_event == '0)
        |=> (flt == $past(flt)))
        else $error("Open load evaluated before the timer expired.");

    AST_LATCH_HOLD: assert property (@(posedge clk_sys)  // R9
        disable iff (!rstn)
        (flt != '0 && !status_read && !soft_rst)
        |=> ((flt & $past(flt)) == $past(flt)))
        else $error("Latched fault lost without a read.");

    AST_READ_CLEAR: assert property (@(posedge clk_sys)  // R9
        disable iff (!rstn)
        (status_read && !soft_rst && ol_event == '0 && sc_event == '0)
        |=> (flt == '0))
        else $error("Status read did not clear the latched faults.");

    AST_THERM_OFF: assert property (@(posedge clk_sys)  // R10 R11 R12
        disable iff (!rstn)
        (!uv && !soft_rst)
        |=> (out_drive == ($past(cmd_reg) & ~$past(tl_s))))
        else $error("Thermal shutdown touched the wrong outputs.");

    AST_SC_SETS: assert property (@(posedge clk_sys)  // R13
        disable iff (!rstn)
        (!soft_rst && (sc_event != '0))
        |=> ((flt & $past(sc_event)) == $past(sc_event)))
        else $error("Short or thermal fault not reported.");

    AST_UV_OFF: assert property (@(posedge clk_sys)  // R14
        disable iff (!rstn)
        uv [*2] |-> (out_drive == '0))
        else $error("Outputs stayed on under undervoltage.");

    AST_HI_ZERO: assert property (@(posedge clk_sys)  // R16
        disable iff (!rstn)
        status_word[osf_pkg::STATUS_W-1:NUM_OUT] == '0)
        else $error("Upper status bits not zero.");
endmodule

// ---- dv/osf_ctrl_model.sv ----
// Controller model: issues command words to the fault logic.
// Assumes the bench calls send_cmd and keeps the spacing between words.
`timescale 1ns/10ps
module osf_ctrl_model (
    input  wire logic       clk_sys,
    output logic            cmd_load,
    output logic [7:0]      cmd_out,
    output logic [7:0]      cmd_old_en
);
    initial
    begin
        cmd_load   = 1'b0;
        cmd_out    = 8'h00;
        cmd_old_en = 8'h00;
    end

    // Outside a load the lines show the inverse, so stale data is never taken.
    task automatic send_cmd(input logic [7:0] c, input logic [7:0] e);
        @(posedge clk_sys);
        cmd_load   <= 1'b1;
        cmd_out    <= c;
        cmd_old_en <= e;
        @(posedge clk_sys);
        cmd_load   <= 1'b0;
        cmd_out    <= ~c;
        cmd_old_en <= ~e;
    endtask
endmodule

// ---- dv/osf_fault_logic_tb.sv ----
// Self-checking bench for osf_fault_logic with an integer reference model.
// Assumes a 50 MHz clock and a shortened filter count of 20 cycles.
`timescale 1ns/10ps
module osf_fault_logic_tb;
    localparam int FILT = 20;
    logic        clk_sys;
    logic        rstn;
    logic        sup_ok;
    logic        en_pin;
    logic        lps_ok;
    logic        cmd_load;
    logic [7:0]  cmd_out;
    logic [7:0]  cmd_en;
    logic        st_rd;
    logic [7:0]  ol;
    logic [7:0]  sh;
    logic [7:0]  th;
    logic [7:0]  drv;
    logic [7:0]  cur_en;
    logic [15:0] st;
    logic        fdone;
    logic [7:0]  nc;
    logic [7:0]  ne;
    int          err_total;
    int          n_checks;
    int          seed;
    int          m_cmd;
    int          m_en;
    int          m_lat;
    int          m_ol;
    int          m_sh;
    int          m_th;

    initial clk_sys = 1'b0;
    always #10 clk_sys = ~clk_sys;

    osf_ctrl_model i_ctrl (.clk_sys(clk_sys), .cmd_load(cmd_load),
        .cmd_out(cmd_out), .cmd_old_en(cmd_en));

    osf_fault_logic #(.FILT_CYC(FILT)) i_dut (.clk_sys(clk_sys), .rstn(rstn),
        .logic_supply_ok(sup_ok), .enable_pin(en_pin),
        .load_power_supply_ok(lps_ok), .cmd_load(cmd_load),
        .cmd_out(cmd_out), .cmd_old_en(cmd_en), .status_read(st_rd),
        .open_load_cmp(ol), .short_cmp(sh), .thermal_limit(th),
        .out_drive(drv), .old_current_en(cur_en), .status_word(st),
        .filter_done(fdone));

    task automatic chk_vec(input string nm, input logic [15:0] exp,
                           input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check_all();
        #1;
        chk_vec("old_current_en", 16'(m_en), {8'h00, cur_en});
        chk_vec("out_drive", 16'(m_cmd & ~m_th & 255), {8'h00, drv});
        chk_vec("status_word", 16'(m_lat), st);
    endtask

    task automatic set_cond(input int o, input int s, input int t);
        @(posedge clk_sys);
        m_ol = o;
        m_sh = s;
        m_th = t;
        ol <= 8'(o);
        sh <= 8'(s);
        th <= 8'(t);
        m_lat = m_lat | (~m_cmd & m_en & o) | (m_cmd & (s | t));
    endtask

    // Counts edges until the filter expires; a stuck timer ends the run.
    task automatic wait_done(input int exp);
        int n;
        n = 0;
        while (fdone !== 1'b1)
        begin
            @(posedge clk_sys);
            #1;
            n++;
            if (n > 4 * FILT)
            begin
                err_total++;
                wrap_up();
            end
        end
        chk_vec("filter_cycles", 16'(exp), 16'(n));
    endtask

    initial
    begin
        seed = 32'h0d875fd5;
        {err_total, n_checks, m_cmd, m_en, m_lat, m_ol, m_sh, m_th} = '0;
        {rstn, st_rd, ol, sh, th} = '0;
        {sup_ok, en_pin, lps_ok} = 3'b111;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check_all();
        for (int i = 0; i < 8; i++)
        begin
            nc = 8'($random(seed));
            ne = 8'($random(seed));
            i_ctrl.send_cmd(~nc, ne);
            repeat (FILT - 4) @(posedge clk_sys);
            i_ctrl.send_cmd(nc, ne);
            m_cmd = nc;
            m_en = ne;
            set_cond($random(seed) & 255, $random(seed) & 255,
                     $random(seed) & 255);
            // The take was one edge before set_cond, so FILT - 1 remain.
            wait_done(FILT - 1);
            repeat (4) @(posedge clk_sys);
            check_all();
            set_cond(0, 0, 0);
            repeat (4) @(posedge clk_sys);
            check_all();
            @(posedge clk_sys);
            st_rd <= 1'b1;
            @(posedge clk_sys);
            st_rd <= 1'b0;
            m_lat = 0;
            @(posedge clk_sys);
            check_all();
            repeat (FILT) @(posedge clk_sys);
        end
        for (int k = 0; k < 3; k++)
        begin
            i_ctrl.send_cmd(8'hff, 8'hff);
            repeat (FILT + 4) @(posedge clk_sys);
            sup_ok <= (k != 0);
            en_pin <= (k != 1);
            lps_ok <= (k != 2);
            {m_cmd, m_en, m_lat} = '0;
            repeat (4) @(posedge clk_sys);
            check_all();
            i_ctrl.send_cmd(8'h5a, 8'h5a);
            @(posedge clk_sys);
            {sup_ok, en_pin, lps_ok} <= 3'b111;
            repeat (4) @(posedge clk_sys);
            check_all();
        end
        wrap_up();
    end
endmodule
